// ===== rtl/csm_pkg.sv
// constants and types shared by the suspend-mode control block
package csm_pkg;

    // bit positions of the pin inputs inside the synchroniser vector
    localparam int unsigned PIN_SUSPEND_REQUEST_N_N    = 0;
    localparam int unsigned PIN_BURST_READY_N_N    = 1;
    localparam int unsigned PIN_NMI       = 2;
    localparam int unsigned PIN_MASKABLE_INTERRUPT_REQUEST      = 3;
    localparam int unsigned PIN_SMI_N     = 4;
    localparam int unsigned PIN_HOLD      = 5;
    localparam int unsigned PIN_ADDR_HOLD = 6;
    localparam int unsigned PIN_BACKOFF_N = 7;
    localparam int unsigned PIN_FLUSH_N   = 8;
    localparam int unsigned PIN_W         = 9;

    // idle level of every pin after reset: active-low pins high
    localparam logic [PIN_W-1:0] PIN_RST_VAL = 9'h193;

    // counter width and cycle counts in input clocks; MAX_INSTR_AFTER counts instructions
    localparam int unsigned CNT_W              = 6;
    localparam int unsigned SYNC_LAT_CLKS      = 3;
    localparam int unsigned SUSPEND_REQUEST_N_ACK_MIN_CLKS  = 8;
    localparam int unsigned SUSPEND_REQUEST_N_RESUME_CLKS   = 5;
    localparam int unsigned MAX_INSTR_AFTER    = 2;
    localparam int unsigned HALT_ACK_MAX_CLKS  = 40;
    localparam int unsigned HALT_RESUME_CLKS   = 10;

    localparam logic [CNT_W-1:0] ACK_MIN_CNT   = CNT_W'(SUSPEND_REQUEST_N_ACK_MIN_CLKS - 1);
    localparam logic [CNT_W-1:0] RESUME_CNT    = CNT_W'(SUSPEND_REQUEST_N_RESUME_CLKS - 1);
    localparam logic [CNT_W-1:0] HALT_DL_CNT   =
        CNT_W'(HALT_ACK_MAX_CLKS - SYNC_LAT_CLKS - 1);
    localparam logic [CNT_W-1:0] HALT_RES_CNT  = CNT_W'(HALT_RESUME_CLKS - 1);
    localparam logic [CNT_W-1:0] CNT_START     = 6'h01;
    localparam logic [1:0]       INSTR_MAX     = 2'(MAX_INSTR_AFTER);

    // reset values of control state
    localparam logic ACK_N_RST = 1'b1;

    // controller states, gray coded from idle up to each exit state
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_DRAIN = 3'h1,
        ST_GRANT = 3'h3,
        ST_PSUSP = 3'h2,
        ST_PEXIT = 3'h6,
        ST_HWAIT = 3'h4,
        ST_HSUSP = 3'h5,
        ST_HEXIT = 3'h7
    } csm_state_t;

endpackage

// ===== rtl/csm_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module csm_pin_sync
    import csm_pkg::*;
#(
    parameter int unsigned         W       = PIN_W,
    parameter logic [PIN_W-1:0]    RST_VAL = PIN_RST_VAL
) (
    // clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    // raw pins and filtered result
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] pin_o
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;
    logic [W-1:0] out_next;

    // a bit moves only once stages two and three agree
    assign out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg ^ s3_reg));

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s1_reg  <= RST_VAL[W-1:0];
            s2_reg  <= RST_VAL[W-1:0];
            s3_reg  <= RST_VAL[W-1:0];
            out_reg <= RST_VAL[W-1:0];
        end else begin
            s1_reg  <= pin_i;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign pin_o = out_reg;

endmodule

// ===== rtl/csm_suspend_ctrl.sv
// suspend-mode controller: pin and halt entry, timed exit, held interrupts
`timescale 1ns/10ps
module csm_suspend_ctrl
    import csm_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    // device pins
    input  wire logic suspend_request_n_i,
    input  wire logic burst_ready_n_i,
    input  wire logic nmi_i,
    input  wire logic maskable_interrupt_request_i,
    input  wire logic system_mgmt_interrupt_n_i,
    input  wire logic hold_request_i,
    input  wire logic address_hold_request_i,
    input  wire logic backoff_n_i,
    input  wire logic flush_n_i,
    output logic      suspend_ack_n_o,
    output logic      hold_ack_o,
    // configuration bits of config_control_reg_two
    input  wire logic pin_suspend_enable_i,
    input  wire logic halt_suspend_enable_i,
    // core and bus unit
    input  wire logic instr_retire_i,
    input  wire logic pipe_empty_i,
    input  wire logic bus_idle_i,
    input  wire logic halt_cycle_i,
    input  wire logic maskable_interrupt_request_unmasked_i,
    input  wire logic stop_grant_done_i,
    input  wire logic nmi_taken_i,
    input  wire logic maskable_interrupt_request_taken_i,
    input  wire logic smi_taken_i,
    output logic      core_stall_o,
    output logic      stop_grant_req_o,
    output logic      halt_wake_o,
    output logic      held_nmi_o,
    output logic      held_maskable_interrupt_request_o,
    output logic      held_smi_o,
    output logic      addr_float_o,
    output logic      bus_release_o,
    output logic      flush_ack_o
);

    function automatic logic [CNT_W-1:0] cnt_inc(input logic [CNT_W-1:0] c);
        cnt_inc = (c == {CNT_W{1'b1}}) ? c : c + 6'h01;
    endfunction

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;

    csm_state_t       state_reg;
    csm_state_t       state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [1:0]       retire_reg;
    logic [1:0]       retire_next;
    logic             ack_n_reg;
    logic             ack_n_next;
    logic             stall_reg;
    logic             stall_next;
    logic             grant_reg;
    logic             grant_next;
    logic             wake_reg;
    logic             wake_next;
    logic             nmi_prev_reg;
    logic             flush_prev_reg;
    logic             held_nmi_reg;
    logic             held_maskable_interrupt_request_reg;
    logic             held_smi_reg;
    logic             hold_ack_reg;
    logic             afloat_reg;
    logic             release_reg;
    logic             flush_ack_reg;

    assign pin_raw = {flush_n_i, backoff_n_i, address_hold_request_i, hold_request_i,
                      system_mgmt_interrupt_n_i, maskable_interrupt_request_i, nmi_i,
                      burst_ready_n_i, suspend_request_n_i};

    csm_pin_sync #(
        .W       (PIN_W),
        .RST_VAL (PIN_RST_VAL)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (pin_raw),
        .pin_o     (pin_s)
    );

    // decoded conditions
    wire suspend_request_n_req    = ~pin_s[PIN_SUSPEND_REQUEST_N_N];
    wire burst_ready_n        = ~pin_s[PIN_BURST_READY_N_N];
    wire nmi_rise    = pin_s[PIN_NMI] & ~nmi_prev_reg;
    wire maskable_interrupt_request_act    = pin_s[PIN_MASKABLE_INTERRUPT_REQUEST];
    wire smi_act     = ~pin_s[PIN_SMI_N];
    wire flush_fall  = ~pin_s[PIN_FLUSH_N] & flush_prev_reg;
    wire hold_defer  = hold_ack_reg & ~pipe_empty_i;
    wire pin_entry   = suspend_request_n_req & pin_suspend_enable_i & ~hold_defer;
    wire halt_entry  = halt_suspend_enable_i & halt_cycle_i & burst_ready_n;
    wire wake_irq    = nmi_rise | (maskable_interrupt_request_act & maskable_interrupt_request_unmasked_i) | smi_act;
    wire drained     = pipe_empty_i | (retire_reg == INSTR_MAX);
    wire pin_mode    = (state_reg == ST_DRAIN) | (state_reg == ST_GRANT) |
                       (state_reg == ST_PSUSP) | (state_reg == ST_PEXIT);
    wire [1:0] retire_inc = (retire_reg == INSTR_MAX) ? retire_reg :
                            retire_reg + {1'b0, instr_retire_i};

    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_inc(cnt_reg);
        retire_next = retire_inc;
        ack_n_next  = ack_n_reg;
        stall_next  = stall_reg;
        grant_next  = grant_reg;
        wake_next   = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                cnt_next    = CNT_START;
                retire_next = 2'h0;
                if (pin_entry) begin
                    state_next = ST_DRAIN;
                    stall_next = 1'b1;
                end else if (halt_entry) begin
                    state_next = ST_HWAIT;
                    stall_next = 1'b1;
                end
            end
            ST_DRAIN: begin
                if (!suspend_request_n_req) begin
                    state_next = ST_IDLE;
                    stall_next = 1'b0;
                end else if (drained) begin
                    state_next = ST_GRANT;
                    grant_next = 1'b1;
                end
            end
            ST_GRANT: begin
                if (stop_grant_done_i) begin
                    grant_next = 1'b0;
                end
                if (!grant_reg && cnt_reg >= ACK_MIN_CNT) begin
                    state_next = ST_PSUSP;
                    ack_n_next = 1'b0;
                end
            end
            ST_PSUSP: begin
                cnt_next = CNT_START;
                if (!suspend_request_n_req) begin
                    state_next = ST_PEXIT;
                end
            end
            ST_PEXIT: begin
                if (cnt_reg == RESUME_CNT) begin
                    state_next = ST_IDLE;
                    ack_n_next = 1'b1;
                    stall_next = 1'b0;
                end
            end
            ST_HWAIT: begin
                if (pipe_empty_i || cnt_reg == HALT_DL_CNT) begin
                    state_next = ST_HSUSP;
                    ack_n_next = 1'b0;
                end
            end
            ST_HSUSP: begin
                cnt_next = CNT_START;
                if (wake_irq) begin
                    state_next = ST_HEXIT;
                    wake_next  = 1'b1;
                end
            end
            ST_HEXIT: begin
                if (cnt_reg == HALT_RES_CNT) begin
                    state_next = ST_IDLE;
                    ack_n_next = 1'b1;
                    stall_next = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_reg  <= ST_IDLE;
            cnt_reg    <= CNT_START;
            retire_reg <= 2'h0;
            ack_n_reg  <= ACK_N_RST;
            stall_reg  <= 1'b0;
            grant_reg  <= 1'b0;
            wake_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            retire_reg <= retire_next;
            ack_n_reg  <= ack_n_next;
            stall_reg  <= stall_next;
            grant_reg  <= grant_next;
            wake_reg   <= wake_next;
        end
    end

    // held interrupts: set wins over the core's take
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            nmi_prev_reg  <= 1'b0;
            held_nmi_reg  <= 1'b0;
            held_maskable_interrupt_request_reg <= 1'b0;
            held_smi_reg  <= 1'b0;
        end else begin
            nmi_prev_reg  <= pin_s[PIN_NMI];
            held_nmi_reg  <= (pin_mode & nmi_rise) | (held_nmi_reg & ~nmi_taken_i);
            held_maskable_interrupt_request_reg <= (pin_mode & maskable_interrupt_request_act) | (held_maskable_interrupt_request_reg & ~maskable_interrupt_request_taken_i);
            held_smi_reg  <= (pin_mode & smi_act) | (held_smi_reg & ~smi_taken_i);
        end
    end

    // bus ownership requests, honoured in every state
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            flush_prev_reg <= 1'b1;
            hold_ack_reg   <= 1'b0;
            afloat_reg     <= 1'b0;
            release_reg    <= 1'b0;
            flush_ack_reg  <= 1'b0;
        end else begin
            flush_prev_reg <= pin_s[PIN_FLUSH_N];
            hold_ack_reg   <= pin_s[PIN_HOLD] & (hold_ack_reg | bus_idle_i);
            afloat_reg     <= pin_s[PIN_ADDR_HOLD];
            release_reg    <= ~pin_s[PIN_BACKOFF_N];
            flush_ack_reg  <= flush_fall;
        end
    end

    assign suspend_ack_n_o  = ack_n_reg;
    assign core_stall_o     = stall_reg;
    assign stop_grant_req_o = grant_reg;
    assign halt_wake_o      = wake_reg;
    assign held_nmi_o       = held_nmi_reg;
    assign held_maskable_interrupt_request_o      = held_maskable_interrupt_request_reg;
    assign held_smi_o       = held_smi_reg;
    assign hold_ack_o       = hold_ack_reg;
    assign addr_float_o     = afloat_reg;
    assign bus_release_o    = release_reg;
    assign flush_ack_o      = flush_ack_reg;

endmodule

// ===== tb/csm_bus_model.sv
// bus unit model that finishes the stop grant cycle
`timescale 1ns/10ps
module csm_bus_model (
    // clock
    input  wire logic       sys_clk_i,
    // stop grant handshake
    input  wire logic       stop_grant_req_i,
    input  wire logic [1:0] delay_i,
    output logic            stop_grant_done_o
);
    logic [2:0] cnt_reg;
    initial begin
        stop_grant_done_o = 1'b0;
        cnt_reg = 3'h0;
    end
    // one done pulse some clocks after each request, none repeated
    always @(posedge sys_clk_i) begin
        stop_grant_done_o <= 1'b0;
        if (!stop_grant_req_i) begin
            cnt_reg <= 3'h0;
        end else if (cnt_reg == {1'b0, delay_i}) begin
            stop_grant_done_o <= 1'b1;
            cnt_reg <= 3'h7;
        end else if (cnt_reg != 3'h7) begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end
endmodule

// ===== tb/csm_suspend_ctrl_monitor.sv
// concurrent checks on the suspend-mode controller ports
`timescale 1ns/10ps
module csm_suspend_ctrl_monitor (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // watched ports
    input wire logic suspend_request_n_i,
    input wire logic pin_suspend_enable_i,
    input wire logic halt_suspend_enable_i,
    input wire logic halt_cycle_i,
    input wire logic burst_ready_n_i,
    input wire logic address_hold_request_i,
    input wire logic nmi_i,
    input wire logic suspend_ack_n_o,
    input wire logic core_stall_o,
    input wire logic stop_grant_req_o,
    input wire logic halt_wake_o,
    input wire logic held_nmi_o,
    input wire logic addr_float_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_ack_lo9;
        !suspend_ack_n_o ##1 !suspend_ack_n_o [*8];
    endsequence
    sequence s_address_hold_request;
        $rose(address_hold_request_i) ##1 address_hold_request_i [*4];
    endsequence
    property p_rst_ack;
        rst_n_i && !$past(rst_n_i) |-> suspend_ack_n_o;
    endproperty
    property p_ack_min;
        $rose(core_stall_o) && !halt_cycle_i |-> suspend_ack_n_o [*7];
    endproperty
    property p_pin_exit;
        !suspend_ack_n_o && !halt_cycle_i && $rose(suspend_request_n_i)
            |=> !suspend_ack_n_o [*8] ##1 suspend_ack_n_o;
    endproperty
    property p_halt_exit;
        $rose(halt_wake_o) |-> s_ack_lo9 ##1 suspend_ack_n_o;
    endproperty
    property p_halt_ack;
        halt_suspend_enable_i && halt_cycle_i && $fell(burst_ready_n_i) && suspend_ack_n_o
            && !core_stall_o && suspend_request_n_i |-> ##[1:41] !suspend_ack_n_o;
    endproperty
    property p_addr_float;
        s_address_hold_request |=> addr_float_o;
    endproperty
    property p_held_nmi;
        !suspend_ack_n_o && !halt_cycle_i && $rose(nmi_i) ##1 nmi_i [*4] |=> held_nmi_o;
    endproperty
    property p_no_pin_en;
        !core_stall_o && !pin_suspend_enable_i && !halt_cycle_i |=> !core_stall_o;
    endproperty
    property p_grant_order;
        $rose(stop_grant_req_o) |-> core_stall_o && suspend_ack_n_o;
    endproperty
    a_rst_ack: assert property (p_rst_ack) else $error("ack low after reset");
    a_ack_min: assert property (p_ack_min) else $error("ack too early");
    a_pin_exit: assert property (p_pin_exit) else $error("pin exit timing");
    a_halt_exit: assert property (p_halt_exit) else $error("halt exit timing");
    a_halt_ack: assert property (p_halt_ack) else $error("halt ack late");
    a_addr_float: assert property (p_addr_float) else $error("address not floated");
    a_held_nmi: assert property (p_held_nmi) else $error("nmi not held");
    a_no_pin_en: assert property (p_no_pin_en) else $error("disabled pin honoured");
    a_grant_order: assert property (p_grant_order) else $error("stop grant order");
endmodule

// ===== tb/csm_suspend_ctrl_bench.sv
// self-checking bench for the suspend-mode controller
`timescale 1ns/10ps
module csm_suspend_ctrl_bench;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic suspend_request_n_i, burst_ready_n_i, nmi_i, maskable_interrupt_request_i;
    logic system_mgmt_interrupt_n_i, hold_request_i, address_hold_request_i, backoff_n_i;
    logic flush_n_i, pin_suspend_enable_i, halt_suspend_enable_i, instr_retire_i;
    logic pipe_empty_i, bus_idle_i, halt_cycle_i, maskable_interrupt_request_unmasked_i, stop_grant_done_i;
    logic nmi_taken_i, maskable_interrupt_request_taken_i, smi_taken_i, suspend_ack_n_o, hold_ack_o;
    logic core_stall_o, stop_grant_req_o, halt_wake_o, held_nmi_o, held_smi_o;
    logic addr_float_o, bus_release_o, held_maskable_interrupt_request_o, flush_ack_o;
    logic       clk_run = 1'b1;
    logic [1:0] sg_delay = 2'h0;
    logic       exp_q[$];
    int         errors = 0;
    int         tests_run = 0;
    int         cycles = 0;
    int         flush_seen = 0;
    int         seed = 32'hcfbe;

    always #2 if (clk_run) sys_clk_i = ~sys_clk_i;

    csm_suspend_ctrl u_csm_suspend_ctrl (
        .sys_clk_i, .rst_n_i, .suspend_request_n_i, .burst_ready_n_i, .nmi_i,
        .maskable_interrupt_request_i, .system_mgmt_interrupt_n_i, .hold_request_i,
        .address_hold_request_i, .backoff_n_i, .flush_n_i, .suspend_ack_n_o, .hold_ack_o,
        .pin_suspend_enable_i, .halt_suspend_enable_i, .instr_retire_i, .pipe_empty_i,
        .bus_idle_i, .halt_cycle_i, .maskable_interrupt_request_unmasked_i, .stop_grant_done_i, .nmi_taken_i,
        .maskable_interrupt_request_taken_i, .smi_taken_i, .core_stall_o, .stop_grant_req_o, .halt_wake_o,
        .held_nmi_o, .held_maskable_interrupt_request_o, .held_smi_o, .addr_float_o, .bus_release_o,
        .flush_ack_o
    );
    csm_bus_model u_csm_bus_model (
        .sys_clk_i, .stop_grant_req_i(stop_grant_req_o), .delay_i(sg_delay),
        .stop_grant_done_o(stop_grant_done_i)
    );

    task automatic check(input string what, input logic exp, input logic seen);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wait_ack(input logic v);
        for (int i = 0; i < 80 && suspend_ack_n_o !== v; i++) tick(1);
    endtask

    // every acknowledge change after reset takes the oldest expected level
    always @(suspend_ack_n_o) begin
        if (rst_n_i === 1'b1) begin
            check("suspend_ack_n_o", exp_q.size() > 0 ? exp_q.pop_front() : 1'bx,
                  suspend_ack_n_o);
        end
    end
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end
    // flush acknowledge is a one-cycle pulse: count it where it is settled
    always @(negedge sys_clk_i) begin
        if (flush_ack_o === 1'b1) begin
            flush_seen++;
        end
    end

    initial begin
        {suspend_request_n_i, burst_ready_n_i, system_mgmt_interrupt_n_i} = 3'h7;
        {backoff_n_i, flush_n_i, pipe_empty_i, bus_idle_i, maskable_interrupt_request_unmasked_i} = 5'h1f;
        {nmi_i, maskable_interrupt_request_i, hold_request_i, address_hold_request_i} = 4'h0;
        {pin_suspend_enable_i, halt_suspend_enable_i, instr_retire_i, halt_cycle_i} = 4'h0;
        {nmi_taken_i, maskable_interrupt_request_taken_i, smi_taken_i} = 3'h0;
        tick(5);
        rst_n_i = 1'b1;
        tick(1);
        check("ack after reset", 1'b1, suspend_ack_n_o);
        suspend_request_n_i = 1'b0;
        tick(30);
        check("stall while disabled", 1'b0, core_stall_o);
        suspend_request_n_i = 1'b1;
        tick(4);
        $display("test pin disabled done");
        sg_delay = 2'($unsigned($random(seed)));
        pin_suspend_enable_i = 1'b1;
        pipe_empty_i = 1'b0;
        exp_q.push_back(1'b0);
        suspend_request_n_i = 1'b0;
        for (int i = 0; i < 60 && suspend_ack_n_o !== 1'b0; i++) begin
            instr_retire_i = 1'($random(seed));
            tick(1);
        end
        {instr_retire_i, pipe_empty_i, nmi_i, system_mgmt_interrupt_n_i} = 4'h6;
        maskable_interrupt_request_i = 1'b1;
        {hold_request_i, address_hold_request_i, backoff_n_i, flush_n_i} = 4'hc;
        tick(8);
        check("held nmi", 1'b1, held_nmi_o);
        check("held smi", 1'b1, held_smi_o);
        check("held maskable_interrupt_request", 1'b1, held_maskable_interrupt_request_o);
        check("flush ack once", 1'b1, flush_seen == 1);
        check("hold ack", 1'b1, hold_ack_o);
        check("addr float", 1'b1, addr_float_o);
        check("bus release", 1'b1, bus_release_o);
        {nmi_i, maskable_interrupt_request_i, hold_request_i, address_hold_request_i} = 4'h0;
        {system_mgmt_interrupt_n_i, backoff_n_i, flush_n_i} = 3'h7;
        tick(6);
        clk_run = 1'b0;
        #100;
        clk_run = 1'b1;
        check("ack over stopped clock", 1'b0, suspend_ack_n_o);
        check("held nmi kept", 1'b1, held_nmi_o);
        tick(3);
        exp_q.push_back(1'b1);
        suspend_request_n_i = 1'b1;
        wait_ack(1'b1);
        check("held nmi after exit", 1'b1, held_nmi_o);
        check("held maskable_interrupt_request after exit", 1'b1, held_maskable_interrupt_request_o);
        {nmi_taken_i, maskable_interrupt_request_taken_i, smi_taken_i} = 3'h7;
        tick(1);
        {nmi_taken_i, maskable_interrupt_request_taken_i, smi_taken_i} = 3'h0;
        check("held nmi taken", 1'b0, held_nmi_o);
        check("held maskable_interrupt_request taken", 1'b0, held_maskable_interrupt_request_o);
        $display("test pin suspend done");
        {halt_suspend_enable_i, halt_cycle_i, burst_ready_n_i} = 3'h6;
        pipe_empty_i = 1'b0;
        exp_q.push_back(1'b0);
        tick(2);
        burst_ready_n_i = 1'b1;
        wait_ack(1'b0);
        tick(4);
        {maskable_interrupt_request_unmasked_i, maskable_interrupt_request_i} = 2'h1;
        tick(8);
        check("masked maskable_interrupt_request ignored", 1'b0, suspend_ack_n_o);
        exp_q.push_back(1'b1);
        maskable_interrupt_request_unmasked_i = 1'b1;
        wait_ack(1'b1);
        {halt_cycle_i, maskable_interrupt_request_i, pipe_empty_i} = 3'h1;
        tick(4);
        check("ack after halt exit", 1'b1, suspend_ack_n_o);
        $display("test halt suspend done");
        results();
    end
endmodule

bind csm_suspend_ctrl csm_suspend_ctrl_monitor u_csm_suspend_ctrl_monitor (
    .sys_clk_i, .rst_n_i, .suspend_request_n_i, .pin_suspend_enable_i,
    .halt_suspend_enable_i, .halt_cycle_i, .burst_ready_n_i, .address_hold_request_i,
    .nmi_i, .suspend_ack_n_o, .core_stall_o, .stop_grant_req_o, .halt_wake_o, .held_nmi_o,
    .addr_float_o
);
